// [diag_pkg.sv]
package diag_pkg;

  // ****************************************
  // Register map (byte addresses on APB)
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] EVENT_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] SLOT_OFS = 8'h0C;
  localparam logic [7:0] SERVICE_OFS = 8'h10;
  localparam logic [7:0] READ_OFS = 8'h14;
  localparam logic [7:0] RDATA_OFS = 8'h18;

  // ****************************************
  // Station status bit positions
  // ****************************************
  localparam int PRM_FAULT_BIT = 6;
  localparam int EXT_DIAG_BIT = 3;
  localparam int CFG_FAULT_BIT = 2;
  localparam int NOT_SUPP_BIT = 4;
  localparam int NOT_READY_BIT = 1;
  localparam int SYNC_BIT = 5;
  localparam int FREEZE_BIT = 4;
  localparam int WD_BIT = 3;
  localparam int SLAVE_BIT = 2;
  localparam int PRM_REQ_BIT = 0;
  localparam int OVF_BIT = 7;

  // ****************************************
  // Report layout and fixed values
  // ****************************************
  localparam logic [7:0] EXT_HEADER = 8'h09;
  localparam logic [7:0] STATUS_TYPE = 8'h82;
  localparam logic [7:0] STATUS_IDENTIFIER_BYTE = 8'h00;
  localparam logic [7:0] MOD_VALID = 8'h00;
  localparam logic [7:0] MOD_INVALID = 8'h03;
  localparam logic [7:0] STD_LEN = 8'd6;
  localparam logic [7:0] FULL_LEN = 8'd15;
  localparam logic [7:0] MAX_LEN = 8'd241;
  localparam logic [7:0] ADDR_RESET = 8'hFF;

  // Event strobes written by the protocol engine through EVENT_OFS
  typedef struct packed {
    logic prmValid;
    logic prmReject;
    logic cfgReject;
    logic unsupported;
    logic syncCmd;
    logic freezeCmd;
    logic crcError;
    logic clearAll;
  } events_s;

endpackage

// [dp_slave_diagnosis_report.sv]
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module dp_slave_diagnosis_report import diag_pkg::*; #(
  parameter logic [15:0] DEVICE_IDENT = 16'hA5A5, // Arbitrary neutral value
  parameter int REPORT_LEN = 15
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] masterAddr,
  output logic [7:0] reportByte,
  output logic reportValid,
  output logic reportLast
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // A frame shorter than the module status block or past the limit cannot be served
  if (REPORT_LEN < 11 || REPORT_LEN > int'(MAX_LEN)) begin : gBadLen
    $error("REPORT_LEN out of range");
  end

  typedef enum {IDLE, SEND} state_e;

  // ****************************************
  // State
  // ****************************************
  logic prmFault, cfgFault, notSupp, syncMode, freezeMode, crcErr, extEnable;
  logic notReady, wdOn;
  logic [7:0] storedAddr, slotNo;
  logic [31:0] service;
  logic [7:0] byteIdx;
  state_e state;
  logic next_prmFault, next_cfgFault, next_notSupp, next_syncMode, next_freezeMode;
  logic next_crcErr, next_extEnable, next_notReady, next_wdOn;
  logic [7:0] next_storedAddr, next_slotNo, next_byteIdx;
  logic [31:0] next_service, next_prdata;
  state_e next_state;
  logic next_pready, next_pslverr, next_reportValid, next_reportLast;
  logic [7:0] next_reportByte;
  logic [7:0] status1, status2, status3, lenByte, curByte, modStatus;
  events_s ev;
  logic wrAcc, rdAcc, startRead;

  assign wrAcc = psel && penable && pwrite && !pready;
  assign rdAcc = psel && penable && !pwrite && !pready;
  assign ev = (wrAcc && paddr == EVENT_OFS) ? events_s'(pwdata[7:0]) : '0;
  assign startRead = wrAcc && paddr == READ_OFS;

  // Status bytes; master-owned bits left zero for the master to fill
  always_comb begin
    status1 = 8'h00;
    status1[PRM_FAULT_BIT] = prmFault;
    status1[EXT_DIAG_BIT] = extEnable;
    status1[CFG_FAULT_BIT] = cfgFault;
    status1[NOT_SUPP_BIT] = notSupp;
    status1[NOT_READY_BIT] = notReady;
    status2 = 8'h00; // Bit 6 reserved stays zero
    status2[SYNC_BIT] = syncMode;
    status2[FREEZE_BIT] = freezeMode;
    status2[WD_BIT] = wdOn;
    status2[SLAVE_BIT] = 1'b1;
    status2[PRM_REQ_BIT] = prmFault || cfgFault;
    status3 = 8'h00; // Block never overflows, so bit 7 stays clear
    modStatus = crcErr ? MOD_INVALID : MOD_VALID;
    lenByte = EXT_HEADER;
  end

  // Byte selector for the frame, in transmit order
  always_comb begin
    case (byteIdx)
      8'd0: curByte = status1;
      8'd1: curByte = status2;
      8'd2: curByte = status3;
      8'd3: curByte = storedAddr;
      8'd4: curByte = DEVICE_IDENT[15:8];
      8'd5: curByte = DEVICE_IDENT[7:0];
      8'd6: curByte = lenByte;
      8'd7: curByte = STATUS_TYPE; // Device data begins at byte 8
      8'd8: curByte = slotNo;
      8'd9: curByte = STATUS_IDENTIFIER_BYTE;
      8'd10: curByte = modStatus;
      8'd11: curByte = service[31:24];
      8'd12: curByte = service[23:16];
      8'd13: curByte = service[15:8];
      8'd14: curByte = service[7:0];
      default: curByte = 8'h00;
    endcase
  end

  // ****************************************
  // Event flags and APB register writes
  // ****************************************
  always_comb begin
    next_prmFault = prmFault;
    next_cfgFault = cfgFault;
    next_notSupp = notSupp;
    next_syncMode = syncMode;
    next_freezeMode = freezeMode;
    next_crcErr = crcErr;
    next_storedAddr = storedAddr;
    next_extEnable = extEnable;
    next_notReady = notReady;
    next_wdOn = wdOn;
    next_slotNo = slotNo;
    next_service = service;
    if (ev.clearAll) begin
      next_prmFault = 1'b0;
      next_cfgFault = 1'b0;
      next_notSupp = 1'b0;
      next_syncMode = 1'b0;
      next_freezeMode = 1'b0;
      next_crcErr = 1'b0;
    end
    // Sets placed after the clear so a coincident event wins
    if (ev.prmReject) begin
      next_prmFault = 1'b1;
    end else if (ev.prmValid) begin
      next_prmFault = 1'b0;
      next_storedAddr = masterAddr;
    end
    if (ev.cfgReject) next_cfgFault = 1'b1;
    if (ev.unsupported) next_notSupp = 1'b1;
    if (ev.syncCmd) next_syncMode = 1'b1;
    if (ev.freezeCmd) next_freezeMode = 1'b1;
    if (ev.crcError) next_crcErr = 1'b1;
    if (wrAcc) begin
      if (paddr == CTRL_OFS) begin
        next_extEnable = pwdata[0];
        next_notReady = pwdata[1];
        next_wdOn = pwdata[2];
      end else if (paddr == SLOT_OFS) begin
        next_slotNo = pwdata[7:0];
      end else if (paddr == SERVICE_OFS) begin
        next_service = pwdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prmFault <= 1'b0;
      cfgFault <= 1'b0;
      notSupp <= 1'b0;
      syncMode <= 1'b0;
      freezeMode <= 1'b0;
      crcErr <= 1'b0;
      storedAddr <= ADDR_RESET;
      extEnable <= 1'b1;
      notReady <= 1'b1;
      wdOn <= 1'b0;
      slotNo <= 8'h00;
      service <= 32'h0000_0000;
    end else begin
      prmFault <= next_prmFault;
      cfgFault <= next_cfgFault;
      notSupp <= next_notSupp;
      syncMode <= next_syncMode;
      freezeMode <= next_freezeMode;
      crcErr <= next_crcErr;
      storedAddr <= next_storedAddr;
      extEnable <= next_extEnable;
      notReady <= next_notReady;
      wdOn <= next_wdOn;
      slotNo <= next_slotNo;
      service <= next_service;
    end
  end

  // ****************************************
  // Frame streamer: runs by itself once started
  // ****************************************
  always_comb begin
    next_state = state;
    next_byteIdx = byteIdx;
    next_reportValid = 1'b0;
    next_reportLast = 1'b0;
    next_reportByte = reportByte;
    case (state)
      IDLE: begin
        if (startRead) begin
          next_state = SEND;
          next_byteIdx = 8'd0;
        end
      end
      SEND: begin
        next_reportValid = 1'b1;
        next_reportByte = curByte;
        // Short frame without extended block when disabled
        if (byteIdx == (extEnable ? 8'(REPORT_LEN - 1) : (STD_LEN - 8'd1))) begin
          next_reportLast = 1'b1;
          next_state = IDLE;
        end else begin
          next_byteIdx = byteIdx + 8'd1;
        end
      end
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= IDLE;
      byteIdx <= 8'd0;
      reportValid <= 1'b0;
      reportLast <= 1'b0;
      reportByte <= 8'h00;
    end else begin
      state <= next_state;
      byteIdx <= next_byteIdx;
      reportValid <= next_reportValid;
      reportLast <= next_reportLast;
      reportByte <= next_reportByte;
    end
  end

  // ****************************************
  // APB slave: one wait cycle, then pready
  // ****************************************
  always_comb begin
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (rdAcc) begin
      next_pready = 1'b1;
      if (paddr == CTRL_OFS) begin
        next_prdata = {29'h0, wdOn, notReady, extEnable};
      end else if (paddr == STATUS_OFS) begin
        next_prdata = {8'h00, status3, status2, status1};
      end else if (paddr == SLOT_OFS) begin
        next_prdata = {24'h0, slotNo};
      end else if (paddr == SERVICE_OFS) begin
        next_prdata = service;
      end else if (paddr == RDATA_OFS) begin
        next_prdata = {16'h0, modStatus, storedAddr};
      end else if (paddr != EVENT_OFS && paddr != READ_OFS) begin
        next_pslverr = 1'b1; // Unmapped address
      end
    end else if (wrAcc) begin
      next_pready = 1'b1;
      if (paddr != CTRL_OFS && paddr != EVENT_OFS && paddr != SLOT_OFS &&
          paddr != SERVICE_OFS && paddr != READ_OFS) begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence startSeq;
    state == IDLE && startRead;
  endsequence

  sequence firstByteSeq;
    reportValid && reportByte[SLAVE_BIT] == 1'b0;
  endsequence

  slave_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    status2[SLAVE_BIT] && !status2[6]) else $error("slave bit wrong");
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    status3[6:0] == 7'h00 && status1[7] == 1'b0 && status1[5] == 1'b0)
    else $error("reserved bit set");
  frame_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    startSeq |-> ##2 (reportValid && reportByte == status1 && !$past(reportValid)))
    else $error("frame start wrong");
  ident_order_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    startSeq |-> ##6 reportByte == DEVICE_IDENT[15:8] ##1 reportByte == DEVICE_IDENT[7:0])
    else $error("ident order wrong");
  header_byte_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (startSeq and extEnable) |-> ##8 reportByte == EXT_HEADER ##1 reportByte == STATUS_TYPE)
    else $error("header wrong");
  frame_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (startSeq and extEnable) |-> ##16 reportLast) else $error("frame length wrong");
  prm_fault_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ev.prmReject |=> status1[PRM_FAULT_BIT] && status2[PRM_REQ_BIT])
    else $error("parameter fault not flagged");
  cfg_fault_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ev.cfgReject |=> status1[CFG_FAULT_BIT]) else $error("config fault not flagged");
  sync_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ev.syncCmd |=> status2[SYNC_BIT])
    else $error("sync not flagged");
  freeze_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ev.freezeCmd |=> status2[FREEZE_BIT])
    else $error("freeze not flagged");
  master_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ev.prmValid && !ev.prmReject |=> storedAddr == $past(masterAddr))
    else $error("master address not stored");
  crc_status_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ev.crcError |=> modStatus == MOD_INVALID) else $error("module status wrong");
  apb_answer_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    psel && penable && !pready |=> pready) else $error("apb answer late");

endmodule // dp_slave_diagnosis_report

// [diag_master_model.sv]
`timescale 1ns/100ps
// ****************************************
// Master side: collects one diagnosis frame
// ****************************************
module diag_master_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clearCap,
  input wire logic [7:0] reportByte,
  input wire logic reportValid,
  input wire logic reportLast,
  output logic [7:0] frameBuf [0:15],
  output logic [7:0] byteCount,
  output logic [7:0] lastIdx,
  output logic frameDone
);
  // Frame is taken as it arrives, nothing to program
  // Master-owned status bits are left as received, never patched here
  always_ff @(posedge ref_clk) begin
    if (!rst_n || clearCap) begin
      byteCount <= 8'h00;
      lastIdx <= 8'hFF;
      frameDone <= 1'b0;
    end else if (reportValid) begin
      // Extra bytes past 16 are only counted, the buffer would overflow
      if (byteCount < 8'h10) frameBuf[byteCount[3:0]] <= reportByte;
      byteCount <= byteCount + 8'h01;
      if (reportLast) begin
        lastIdx <= byteCount;
        frameDone <= 1'b1;
      end
    end
  end
endmodule // diag_master_model

// [dp_slave_diagnosis_report_bench.sv]
`timescale 1ns/100ps
module dp_slave_diagnosis_report_bench import diag_pkg::*;;
  logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, masterAddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, reportValid, reportLast, clearCap = 1'b0, er;
  logic [7:0] reportByte, byteCount, lastIdx;
  logic [7:0] frameBuf [0:15];
  logic [7:0] expB [0:14];
  logic frameDone;
  int numErrors = 0, totalChecks = 0;
  dp_slave_diagnosis_report i_dp_slave_diagnosis_report (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .masterAddr(masterAddr),
    .reportByte(reportByte), .reportValid(reportValid), .reportLast(reportLast));
  diag_master_model i_diag_master_model (.ref_clk(ref_clk), .rst_n(rst_n), .clearCap(clearCap),
    .reportByte(reportByte), .reportValid(reportValid), .reportLast(reportLast),
    .frameBuf(frameBuf), .byteCount(byteCount), .lastIdx(lastIdx), .frameDone(frameDone));
  initial forever #25 ref_clk = ~ref_clk;
  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic complete_run();
    $display("Checks made %0d, mismatches %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One idle edge first so psel never gets two values in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) begin
      numErrors++;
      complete_run();
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, exp, rd);
    check({what, " err"}, 32'h0, {31'h0, er});
  endtask
  // Starts a frame and compares every byte with expB
  task automatic frame_chk(input int len);
    int n;
    @(posedge ref_clk);
    clearCap <= 1'b1;
    @(posedge ref_clk);
    clearCap <= 1'b0;
    apb(1'b1, READ_OFS, 32'h1);
    n = 0;
    while (frameDone !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    // A frame that never ends is a mismatch, not a silent pass
    if (n >= 300) begin
      numErrors++;
      complete_run();
    end
    repeat (4) @(posedge ref_clk);
    check("frame length", len, {24'h0, byteCount});
    check("last flag index", len - 1, {24'h0, lastIdx});
    for (int i = 0; i < len; i++) check($sformatf("byte %0d", i + 1), expB[i], frameBuf[i]);
    $display("Test frame of %0d bytes done", len);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk("status reset", STATUS_OFS, 32'h0000040A);
    rd_chk("rdata reset", RDATA_OFS, {16'h0, MOD_VALID, ADDR_RESET});
    masterAddr <= 8'h2A; // Address for the accepted telegram, the rejected one sees 8'h33
    apb(1'b1, EVENT_OFS, 32'h80);
    rd_chk("stored address", RDATA_OFS, 32'h0000002A);
    masterAddr <= 8'h33;
    apb(1'b1, EVENT_OFS, 32'hC0);
    rd_chk("rejected prm", RDATA_OFS, 32'h0000002A);
    rd_chk("prm fault", STATUS_OFS, 32'h0000054A);
    apb(1'b1, EVENT_OFS, 32'h01);
    apb(1'b1, CTRL_OFS, 32'h5);
    rd_chk("ctrl", CTRL_OFS, 32'h5);
    rd_chk("watchdog ready", STATUS_OFS, 32'h00000C08);
    apb(1'b1, SLOT_OFS, 32'h07);
    apb(1'b1, SERVICE_OFS, 32'h11223344);
    apb(1'b1, EVENT_OFS, 32'h02);
    rd_chk("crc module", RDATA_OFS, {16'h0, MOD_INVALID, 8'h2A});
    $display("Test registers done");
    expB = '{8'h08, 8'h0C, 8'h00, 8'h2A, 8'hA5, 8'hA5, FULL_LEN - STD_LEN, 8'h82, 8'h07,
      8'h00, 8'h03, 8'h11, 8'h22, 8'h33, 8'h44};
    frame_chk(15);
    apb(1'b1, CTRL_OFS, 32'h4);
    expB[0] = 8'h00;
    frame_chk(6);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped err", 32'h1, {31'h0, er});
    check("unmapped data", 32'h0, rd);
    // Events pile up without a clear in between
    apb(1'b1, EVENT_OFS, 32'h08);
    rd_chk("sync", STATUS_OFS, 32'h00002C00);
    apb(1'b1, EVENT_OFS, 32'h04);
    rd_chk("freeze", STATUS_OFS, 32'h00003C00);
    apb(1'b1, EVENT_OFS, 32'h20);
    rd_chk("cfg fault", STATUS_OFS, 32'h00003D04);
    apb(1'b1, EVENT_OFS, 32'h10);
    rd_chk("unsupported", STATUS_OFS, 32'h00003D14);
    $display("Test events done");
    complete_run();
  end
endmodule // dp_slave_diagnosis_report_bench
